// ### oss_step_sequencer.sv
/*
 Operator step sequencer: two sequences of programmable steps, manual
 and weight-triggered starts, loop, abort and latched target enable.
 Assumes a classic Wishbone master on mclk, a step executor answering
 with stepDone/stepFail pulses on mclk, and asynchronous keypad pins.
*/
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
`include "oss_cfg.svh"

module oss_step_sequencer #(
  parameter int STEPS = `OSS_MAX_STEPS,
  parameter int WEIGHT_W = 24
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [8:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic ack_o,
  output logic [31:0] dat_o,
  input wire logic [WEIGHT_W-1:0] weight,
  input wire logic weightValid,
  input wire logic stepDone,
  input wire logic stepFail,
  input wire oss_pkg::oss_pins_t pinIn,
  output oss_pkg::oss_cmd_t stepCmd,
  output oss_pkg::oss_disp_t disp,
  output logic targetRun,
  output logic busyEvt
);

  if (STEPS < 1 || STEPS > 31) begin : g_bad_steps
    $error("STEPS must lie in 1..31");
  end
  if (WEIGHT_W < 1 || WEIGHT_W > 32) begin : g_bad_weight
    $error("WEIGHT_W must lie in 1..32");
  end

  // byte-lane merge of a write
  function automatic logic [31:0] wrMerge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // step window hit for one sequence
  function automatic logic stepHit(input logic [8:0] a, input logic which);
    return (a[8:7] == (which ? `OSS_WIN_SEQ2 : `OSS_WIN_SEQ1)) &&
           (32'(a[6:2]) < STEPS);
  endfunction

  // counts above the memory depth are clamped
  function automatic logic [4:0] clampCnt(input logic [4:0] c);
    return (32'(c) > STEPS) ? 5'(STEPS) : c;
  endfunction

  logic [31:0] ctrl_reg, thresh_reg, rearm_reg, count_reg;
  logic [31:0] rdData;
  oss_pkg::oss_step_t stepMem [2][STEPS];
  oss_pkg::oss_state_t state_reg;
  logic seq_reg, manual_reg, busy_reg, abort_reg, tgt_reg;
  logic [4:0] idx_reg;
  logic [1:0] armed_reg;
  oss_pkg::oss_pins_t s1_reg, s2_reg, s3_reg, filt_reg, prev_reg;

  // bus request phases: answer one cycle after request, commit on ack
  logic busReq, wrCommit;
  assign busReq = cyc_i && stb_i && !ack_o;
  assign wrCommit = cyc_i && stb_i && we_i && ack_o;

  // register read decode
  always_comb begin
    rdData = 32'h0000_0000;
    unique case (adr_i)
      `OSS_ADR_CTRL: rdData = ctrl_reg;
      `OSS_ADR_STAT: begin
        rdData[`OSS_STAT_RUN] = (state_reg != oss_pkg::ST_IDLE);
        rdData[`OSS_STAT_SEQ] = seq_reg;
        rdData[`OSS_STAT_IDX +: 5] = idx_reg;
        rdData[`OSS_STAT_BUSY] = busy_reg;
        rdData[`OSS_STAT_ABORT] = abort_reg;
        rdData[`OSS_STAT_ARMED +: 2] = armed_reg;
        rdData[`OSS_STAT_TGT] = tgt_reg;
      end
      `OSS_ADR_THRESH: rdData = thresh_reg;
      `OSS_ADR_REARM: rdData = rearm_reg;
      `OSS_ADR_COUNT: rdData = count_reg;
      default: begin
        if (stepHit(adr_i, 1'b0)) begin
          rdData[3:0] = stepMem[0][adr_i[6:2]];
        end else if (stepHit(adr_i, 1'b1)) begin
          rdData[3:0] = stepMem[1][adr_i[6:2]];
        end
      end
    endcase
  end

  // wishbone answer; unmapped addresses ack with zero data
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= busReq;
      if (busReq) begin
        dat_o <= rdData;
      end
    end
  end

  // configuration registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= `OSS_CTRL_RST;
      thresh_reg <= `OSS_THRESH_RST;
      rearm_reg <= `OSS_REARM_RST;
      count_reg <= `OSS_COUNT_RST;
    end else if (wrCommit) begin
      if (adr_i == `OSS_ADR_CTRL) ctrl_reg <= wrMerge(ctrl_reg, dat_i, sel_i);
      if (adr_i == `OSS_ADR_THRESH) thresh_reg <= wrMerge(thresh_reg, dat_i, sel_i);
      if (adr_i == `OSS_ADR_REARM) rearm_reg <= wrMerge(rearm_reg, dat_i, sel_i);
      if (adr_i == `OSS_ADR_COUNT && sel_i[0]) begin
        count_reg[4:0] <= clampCnt(dat_i[4:0]);
      end
      if (adr_i == `OSS_ADR_COUNT && sel_i[1]) begin
        count_reg[`OSS_COUNT_SEQ2 +: 5] <= clampCnt(dat_i[`OSS_COUNT_SEQ2 +: 5]);
      end
    end
  end

  // step memory, two sequences; kinds outside the list read back as stored
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int s = 0; s < 2; s++) begin
        for (int i = 0; i < STEPS; i++) begin
          stepMem[s][i] <= oss_pkg::OSS_ALPHA;
        end
      end
    end else if (wrCommit && sel_i[0]) begin
      for (int s = 0; s < 2; s++) begin
        if (stepHit(adr_i, s[0])) begin
          stepMem[s][adr_i[6:2]] <= oss_pkg::oss_step_t'(dat_i[3:0]);
        end
      end
    end
  end

  // pin synchroniser; a change counts once stages two and three agree
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      filt_reg <= '0;
      prev_reg <= '0;
    end else begin
      s1_reg <= pinIn;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) filt_reg <= s3_reg;
      prev_reg <= filt_reg;
    end
  end

  oss_pkg::oss_pins_t rise;
  assign rise = filt_reg & ~prev_reg;

  // software strobes, valid only in the commit cycle
  logic [4:0] cmdHit;
  assign cmdHit = (wrCommit && adr_i == `OSS_ADR_CMD && sel_i[0]) ? dat_i[4:0] : 5'h00;

  logic [1:0] keyMapA, manReq, autoReq, cntOk;
  logic [3:0] keyMap;
  logic [4:0] cnt1, cnt2, cntCur;
  logic exitReq;
  oss_pkg::oss_step_t curKind;
  assign keyMap = ctrl_reg[`OSS_CTRL_KEYMAP +: 4];
  assign keyMapA = {|(rise.appKey & keyMap), |(rise.appKey & ~keyMap)};
  // manual start sources for each sequence
  assign manReq = rise.softKey | rise.discStart | keyMapA | cmdHit[`OSS_CMD_TRIG +: 2];
  assign cnt1 = count_reg[4:0];
  assign cnt2 = count_reg[`OSS_COUNT_SEQ2 +: 5];
  assign cntOk = {cnt2 != 5'h00, cnt1 != 5'h00};
  assign cntCur = seq_reg ? cnt2 : cnt1;
  assign curKind = stepMem[seq_reg][idx_reg];
  assign exitReq = rise.exitKey || cmdHit[`OSS_CMD_EXIT];

  // weight-triggered start
  logic overThr, underRearm;
  assign overThr = weightValid && (weight > thresh_reg[WEIGHT_W-1:0]);
  assign underRearm = weightValid && (weight < rearm_reg[WEIGHT_W-1:0]);
  assign autoReq = ctrl_reg[`OSS_CTRL_AUTO +: 2] & armed_reg & {2{overThr}};

  // run control decisions
  logic startNow, startSeq, startMan, advanceNow, endNow, failNow, lastStep;
  assign lastStep = (idx_reg == cntCur - 5'h01);
  always_comb begin
    startNow = 1'b0;
    startSeq = 1'b0;
    startMan = 1'b0;
    if (state_reg == oss_pkg::ST_IDLE) begin
      if (manReq[0] && cntOk[0]) begin
        startNow = 1'b1;
        startMan = 1'b1;
      end else if (manReq[1] && cntOk[1]) begin
        startNow = 1'b1;
        startSeq = 1'b1;
        startMan = 1'b1;
      end else if (autoReq[0] && cntOk[0]) begin
        startNow = 1'b1;
      end else if (autoReq[1] && cntOk[1]) begin
        startNow = 1'b1;
        startSeq = 1'b1;
      end
    end
  end

  always_comb begin
    advanceNow = 1'b0;
    failNow = 1'b0;
    unique case (state_reg)
      oss_pkg::ST_WAIT: begin
        failNow = stepFail;
        advanceNow = stepDone && !stepFail;
      end
      oss_pkg::ST_ENTER: advanceNow = rise.enterKey;
      oss_pkg::ST_ISSUE: advanceNow = (curKind == oss_pkg::OSS_LOOP) && !manual_reg;
      default: advanceNow = 1'b0;
    endcase
  end

  // exit always ends; escape only while an alphanumeric entry is open
  assign endNow = (state_reg != oss_pkg::ST_IDLE) &&
                  (exitReq || failNow || (advanceNow && lastStep) ||
                   (state_reg == oss_pkg::ST_ENTER && rise.escKey &&
                    curKind == oss_pkg::OSS_ALPHA));

  // sequencer state and step index
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= oss_pkg::ST_IDLE;
      seq_reg <= 1'b0;
      manual_reg <= 1'b0;
      idx_reg <= 5'h00;
    end else if (endNow) begin
      state_reg <= oss_pkg::ST_IDLE;
    end else begin
      unique case (state_reg)
        oss_pkg::ST_IDLE: begin
          if (startNow) begin
            state_reg <= oss_pkg::ST_ISSUE;
            seq_reg <= startSeq;
            manual_reg <= startMan;
            idx_reg <= 5'h00;
          end
        end
        oss_pkg::ST_ISSUE: begin
          if (curKind == oss_pkg::OSS_LOOP && manual_reg) begin
            idx_reg <= 5'h00;
          end else if (advanceNow) begin
            idx_reg <= idx_reg + 5'h01;
          end else if (curKind == oss_pkg::OSS_ALPHA || curKind == oss_pkg::OSS_NUMERIC) begin
            state_reg <= oss_pkg::ST_ENTER;
          end else begin
            state_reg <= oss_pkg::ST_WAIT;
          end
        end
        default: begin
          if (advanceNow) begin
            idx_reg <= idx_reg + 5'h01;
            state_reg <= oss_pkg::ST_ISSUE;
          end
        end
      endcase
    end
  end

  // step command pulse; loop steps are handled here and never issued
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stepCmd <= '0;
    end else begin
      stepCmd.valid <= (state_reg == oss_pkg::ST_ISSUE) && !endNow &&
                       (curKind != oss_pkg::OSS_LOOP);
      stepCmd.seq <= seq_reg;
      stepCmd.idx <= idx_reg;
      stepCmd.kind <= curKind;
    end
  end

  // auto trigger arming; cleared at run end so the weight must drop first
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      armed_reg <= 2'h0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        if (endNow && seq_reg == s[0]) armed_reg[s] <= 1'b0;
        else if (underRearm && !(state_reg != oss_pkg::ST_IDLE && seq_reg == s[0])) armed_reg[s] <= 1'b1;
      end
    end
  end

  // sticky busy and abort; a new event beats a software clear
  logic clrStat;
  assign clrStat = wrCommit && adr_i == `OSS_ADR_STAT && sel_i[1];
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busy_reg <= 1'b0;
      abort_reg <= 1'b0;
      busyEvt <= 1'b0;
    end else begin
      busyEvt <= (state_reg != oss_pkg::ST_IDLE) && (|manReq);
      if ((state_reg != oss_pkg::ST_IDLE) && (|manReq)) busy_reg <= 1'b1;
      else if (clrStat && dat_i[`OSS_STAT_BUSY]) busy_reg <= 1'b0;
      if (failNow) abort_reg <= 1'b1;
      else if (clrStat && dat_i[`OSS_STAT_ABORT]) abort_reg <= 1'b0;
    end
  end

  // message area follows the run one cycle later
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      disp <= '0;
    end else begin
      disp.msgArea <= (state_reg != oss_pkg::ST_IDLE);
      disp.seq <= seq_reg;
      disp.stepNum <= idx_reg + 5'h01;
    end
  end

  // latched target enable; off until a start, stopped by pause or stop
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tgt_reg <= 1'b0;
      targetRun <= 1'b0;
    end else begin
      if (!ctrl_reg[`OSS_CTRL_LATCH]) tgt_reg <= 1'b0;
      else if (rise.fillStart || rise.fillResume || cmdHit[`OSS_CMD_TSTART]) tgt_reg <= 1'b1;
      else if (rise.fillPause || cmdHit[`OSS_CMD_TSTOP]) tgt_reg <= 1'b0;
      targetRun <= tgt_reg;
    end
  end

  // checks
  sequence sRunEnd;
    endNow ##1 (state_reg == oss_pkg::ST_IDLE);
  endsequence

  sequence sRefused;
    (state_reg != oss_pkg::ST_IDLE) && (|manReq) && !endNow;
  endsequence

  chk_busy_refused: assert property (@(posedge mclk) disable iff (!nrst)
    sRefused |=> busy_reg && busyEvt && (seq_reg == $past(seq_reg)))
    else $error("start while running not refused");

  chk_enter_hold: assert property (@(posedge mclk) disable iff (!nrst)
    (state_reg == oss_pkg::ST_ENTER) && !rise.enterKey && !endNow |=> state_reg == oss_pkg::ST_ENTER)
    else $error("prompt step left without enter");

  chk_auto_adv: assert property (@(posedge mclk) disable iff (!nrst)
    (state_reg == oss_pkg::ST_WAIT) && stepDone && !stepFail && !endNow |=>
    (state_reg == oss_pkg::ST_ISSUE) && (idx_reg == $past(idx_reg) + 5'h01))
    else $error("done step did not advance");

  chk_fail_abort: assert property (@(posedge mclk) disable iff (!nrst)
    (state_reg == oss_pkg::ST_WAIT) && stepFail |=> (state_reg == oss_pkg::ST_IDLE) && abort_reg)
    else $error("failed step did not abort");

  chk_idx_bound: assert property (@(posedge mclk) disable iff (!nrst)
    (state_reg != oss_pkg::ST_IDLE) |-> (idx_reg < cntCur) && (32'(idx_reg) < STEPS))
    else $error("step index beyond sequence length");

  chk_auto_start: assert property (@(posedge mclk) disable iff (!nrst)
    (state_reg == oss_pkg::ST_IDLE) && autoReq[0] && cntOk[0] && !(|manReq) |=>
    (state_reg == oss_pkg::ST_ISSUE) && !seq_reg && !manual_reg)
    else $error("threshold did not start sequence");

  chk_rearm_gate: assert property (@(posedge mclk) disable iff (!nrst)
    sRunEnd |-> !armed_reg[seq_reg])
    else $error("trigger armed without weight drop");

  chk_loop_back: assert property (@(posedge mclk) disable iff (!nrst)
    (state_reg == oss_pkg::ST_ISSUE) && (curKind == oss_pkg::OSS_LOOP) && manual_reg && !endNow
    |=> (idx_reg == 5'h00) && (state_reg == oss_pkg::ST_ISSUE))
    else $error("manual loop step did not restart");

  chk_disp_restore: assert property (@(posedge mclk) disable iff (!nrst)
    sRunEnd ##1 1'b1 |-> !disp.msgArea)
    else $error("message area kept after run");

  chk_tgt_latch: assert property (@(posedge mclk) disable iff (!nrst)
    !ctrl_reg[`OSS_CTRL_LATCH] |-> ##2 !targetRun)
    else $error("target enabled without latch start");

  chk_cmd_issue: assert property (@(posedge mclk) disable iff (!nrst)
    stepCmd.valid |-> (stepCmd.kind != oss_pkg::OSS_LOOP) && $past(state_reg) == oss_pkg::ST_ISSUE)
    else $error("step command outside issue");

endmodule

// ### oss_cfg.svh
/*
 Register map, field positions and reset values of the step sequencer.
 Assumes a Wishbone slave decoding a 9-bit byte address.
*/
`ifndef OSS_CFG_SVH
`define OSS_CFG_SVH

`define OSS_MAX_STEPS 20
`define OSS_ADR_CTRL 9'h000
`define OSS_ADR_CMD 9'h004
`define OSS_ADR_STAT 9'h008
`define OSS_ADR_THRESH 9'h00c
`define OSS_ADR_REARM 9'h010
`define OSS_ADR_COUNT 9'h014
`define OSS_WIN_SEQ1 2'h1
`define OSS_WIN_SEQ2 2'h2

`define OSS_CTRL_AUTO 0
`define OSS_CTRL_LATCH 2
`define OSS_CTRL_KEYMAP 4
`define OSS_CMD_TRIG 0
`define OSS_CMD_EXIT 2
`define OSS_CMD_TSTART 3
`define OSS_CMD_TSTOP 4
`define OSS_STAT_RUN 0
`define OSS_STAT_SEQ 1
`define OSS_STAT_IDX 2
`define OSS_STAT_BUSY 8
`define OSS_STAT_ABORT 9
`define OSS_STAT_ARMED 10
`define OSS_STAT_TGT 12
`define OSS_COUNT_SEQ2 8

`define OSS_CTRL_RST 32'h0000_0000
`define OSS_THRESH_RST 32'h0000_0000
`define OSS_REARM_RST 32'h0000_0000
`define OSS_COUNT_RST 32'h0000_0000

`endif

// ### oss_pkg.sv
/*
 Types shared by the step sequencer and its bench.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package oss_pkg;

  // step kinds held in the step memory
  typedef enum logic [3:0] {
    OSS_ALPHA = 4'h0, OSS_NUMERIC = 4'h1, OSS_CLRTARE = 4'h2,
    OSS_PRINT = 4'h3, OSS_SELSCALE = 4'h4, OSS_SELTARE = 4'h5,
    OSS_SELTGT = 4'h6, OSS_LOOP = 4'h7, OSS_AUTOTARE = 4'h8,
    OSS_PRESET = 4'h9
  } oss_step_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_ISSUE = 4'h2, ST_WAIT = 4'h4, ST_ENTER = 4'h8
  } oss_state_t;

  // step command towards the executor
  typedef struct packed {
    logic valid;
    logic seq;
    logic [4:0] idx;
    oss_step_t kind;
  } oss_cmd_t;

  // keypad and discrete pins
  typedef struct packed {
    logic enterKey;
    logic exitKey;
    logic escKey;
    logic [1:0] softKey;
    logic [3:0] appKey;
    logic [1:0] discStart;
    logic fillStart;
    logic fillPause;
    logic fillResume;
  } oss_pins_t;

  // message area state
  typedef struct packed {
    logic msgArea;
    logic seq;
    logic [4:0] stepNum;
  } oss_disp_t;

endpackage

// ### oss_exec_model.sv
/*
 Step executor model for the sequencer bench: answers each issued
 non-prompt step with a done or fail pulse, alternately fast and slow.
 Assumes stepCmd from the sequencer and failure control from the bench.
*/
`timescale 1ns/10ps

module oss_exec_model (
  input wire logic mclk,
  input wire logic nrst,
  input wire oss_pkg::oss_cmd_t stepCmd,
  input wire logic failEn,
  input wire oss_pkg::oss_step_t failKind,
  output logic stepDone,
  output logic stepFail
);
  logic [3:0] waitCnt;
  logic slow;
  logic pend;
  logic bad;

  // prompt kinds wait for the enter key, so only other kinds get an answer
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stepDone <= 1'b0;
      stepFail <= 1'b0;
      waitCnt <= 4'h0;
      slow <= 1'b0;
      pend <= 1'b0;
      bad <= 1'b0;
    end else begin
      stepDone <= 1'b0;
      stepFail <= 1'b0;
      if (stepCmd.valid && stepCmd.kind != oss_pkg::OSS_ALPHA && stepCmd.kind != oss_pkg::OSS_NUMERIC) begin
        pend <= 1'b1;
        bad <= failEn && (stepCmd.kind == failKind);
        waitCnt <= slow ? 4'h6 : 4'h0; // slow answers stress the wait state
        slow <= !slow;
      end else if (pend && waitCnt != 4'h0) begin
        waitCnt <= waitCnt - 4'h1;
      end else if (pend) begin
        pend <= 1'b0;
        stepDone <= !bad;
        stepFail <= bad;
      end
    end
  end
endmodule

// ### operator_step_sequencer_bench.sv
/*
 Self-checking bench for the step sequencer: registers, keyed, shared
 and weight starts, loop, busy, abort and target latch.
 Assumes the executor model answers steps; keys held 8 cycles per press.
*/
`timescale 1ns/10ps
`include "oss_cfg.svh"

module operator_step_sequencer_bench;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [8:0] adr = 9'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic ack;
  logic [31:0] rdat;
  logic [23:0] weight = 24'h0;
  logic weightValid = 1'b1;
  logic stepDone;
  logic stepFail;
  logic failEn = 1'b0;
  oss_pkg::oss_pins_t pins = 14'h0000;
  oss_pkg::oss_cmd_t stepCmd;
  oss_pkg::oss_disp_t disp;
  logic targetRun;
  logic busyEvt;
  int errors = 0;
  int total_checks = 0;
  int busyN = 0;
  oss_pkg::oss_cmd_t cmds[$];
  oss_pkg::oss_disp_t dsp[$];
  logic [31:0] q;

  oss_step_sequencer oss_step_sequencer_i (.mclk(mclk), .nrst(nrst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .ack_o(ack), .dat_o(rdat), .weight(weight),
    .weightValid(weightValid), .stepDone(stepDone), .stepFail(stepFail), .pinIn(pins),
    .stepCmd(stepCmd), .disp(disp), .targetRun(targetRun), .busyEvt(busyEvt));
  oss_exec_model oss_exec_model_i (.mclk(mclk), .nrst(nrst), .stepCmd(stepCmd), .failEn(failEn),
    .failKind(oss_pkg::OSS_AUTOTARE), .stepDone(stepDone), .stepFail(stepFail));

  // 20 MHz clock
  initial begin
    forever #25 mclk = ~mclk;
  end

  // one-cycle pulses are logged at the edge that samples them
  always @(posedge mclk) begin
    if (stepCmd.valid === 1'b1) begin
      cmds.push_back(stepCmd);
      dsp.push_back(disp);
    end
    if (busyEvt === 1'b1) busyN++;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // classic cycle: hold until ack sampled, take data at that edge
  task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    // no cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd(input logic [8:0] a, input logic [31:0] e, input string n);
    wb(1'b0, a, 32'h0);
    chk(n, e, q);
  endtask

  // long enough for the pin synchroniser and filter
  task automatic press(input int b);
    @(posedge mclk);
    pins[b] <= 1'b1;
    repeat (8) @(posedge mclk);
    pins[b] <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask

  task automatic wait_cmds(input int n);
    int t;
    t = 0;
    while (cmds.size() < n && t < 400) begin
      @(posedge mclk);
      t++;
    end
    chk("command count", n, cmds.size());
  endtask

  task automatic wait_idle();
    int t;
    t = 0;
    while (disp.msgArea !== 1'b0 && t < 400) begin
      @(posedge mclk);
      t++;
    end
    chk("message area after run", 1'b0, disp.msgArea);
  endtask

  task automatic chk_cmd(input int i, input oss_pkg::oss_step_t k, input logic s, input logic [4:0] x);
    chk("step kind", k, cmds[i].kind);
    chk("step sequence", s, cmds[i].seq);
    chk("step index", x, cmds[i].idx);
    chk("step number", x + 5'h01, dsp[i].stepNum);
    chk("message area", 1'b1, dsp[i].msgArea);
  endtask

  task automatic t_regs();
    rd(`OSS_ADR_CTRL, `OSS_CTRL_RST, "ctrl reset");
    rd(`OSS_ADR_STAT, 32'h0, "stat reset");
    rd(`OSS_ADR_COUNT, `OSS_COUNT_RST, "count reset");
    rd(`OSS_ADR_THRESH, `OSS_THRESH_RST, "threshold reset");
    wr(9'h040, 32'hffffffff);
    rd(9'h040, 32'h0, "unmapped read");
    wr(`OSS_ADR_COUNT, 32'h1f1f);
    rd(`OSS_ADR_COUNT, 32'h1414, "count clamp");
    for (int k = 0; k < 10; k++) begin
      wr(9'h100 + 9'(4 * k), 32'(k));
      rd(9'h100 + 9'(4 * k), 32'(k), "step kind readback");
    end
    $display("done registers");
  endtask

  task automatic t_run();
    cmds.delete();
    dsp.delete();
    wr(9'h080, 32'h3);
    wr(9'h084, 32'h1);
    wr(9'h088, 32'h2);
    wr(`OSS_ADR_COUNT, 32'h0203);
    press(7);
    wait_cmds(2);
    repeat (30) @(posedge mclk);
    chk("prompt holds", 2, cmds.size());
    press(13);
    wait_cmds(3);
    wait_idle();
    chk_cmd(0, oss_pkg::OSS_PRINT, 1'b0, 5'h00);
    chk_cmd(1, oss_pkg::OSS_NUMERIC, 1'b0, 5'h01);
    chk_cmd(2, oss_pkg::OSS_CLRTARE, 1'b0, 5'h02);
    $display("done plain run");
  endtask

  task automatic t_loop();
    cmds.delete();
    dsp.delete();
    busyN = 0;
    wr(9'h100, 32'h0);
    wr(9'h104, 32'h7);
    wr(`OSS_ADR_CMD, 32'h2);
    wait_cmds(1);
    press(13);
    wait_cmds(2);
    press(9);
    chk("busy pulses", 1, busyN);
    rd(`OSS_ADR_STAT, 32'h103, "stat busy running");
    press(11);
    wait_idle();
    chk_cmd(1, oss_pkg::OSS_ALPHA, 1'b1, 5'h00);
    wr(`OSS_ADR_STAT, 32'h100);
    rd(`OSS_ADR_STAT, 32'h2, "stat busy cleared"); // seq field keeps the last run
    chk("no stray run", 2, cmds.size());
    // application key mapped to sequence two, loop left by the exit key
    wr(`OSS_ADR_CTRL, 32'h10);
    press(5);
    wait_cmds(3);
    press(12);
    wait_idle();
    chk_cmd(2, oss_pkg::OSS_ALPHA, 1'b1, 5'h00);
    chk("exit ends loop", 3, cmds.size());
    $display("done loop and busy");
  endtask

  task automatic t_fail();
    cmds.delete();
    dsp.delete();
    wr(9'h080, 32'h8);
    wr(9'h084, 32'h3);
    wr(`OSS_ADR_COUNT, 32'h0202);
    failEn <= 1'b1;
    press(3);
    wait_cmds(1);
    wait_idle();
    repeat (20) @(posedge mclk);
    chk("abort stops run", 1, cmds.size());
    rd(`OSS_ADR_STAT, 32'h200, "stat abort");
    failEn <= 1'b0;
    wr(`OSS_ADR_STAT, 32'h200);
    press(3);
    wait_cmds(3);
    wait_idle();
    chk_cmd(2, oss_pkg::OSS_PRINT, 1'b0, 5'h01);
    $display("done abort");
  endtask

  task automatic t_auto();
    cmds.delete();
    dsp.delete();
    wr(`OSS_ADR_THRESH, 32'd100);
    wr(`OSS_ADR_REARM, 32'd10);
    rd(`OSS_ADR_THRESH, 32'd100, "threshold readback");
    wr(`OSS_ADR_CTRL, 32'h1);
    weight <= 24'd100;
    repeat (30) @(posedge mclk);
    chk("no start at threshold", 0, cmds.size());
    weight <= 24'd200;
    wait_cmds(2);
    wait_idle();
    repeat (40) @(posedge mclk);
    chk("stays disarmed", 2, cmds.size());
    weight <= 24'd5;
    repeat (10) @(posedge mclk);
    weight <= 24'd200;
    wait_cmds(4);
    wait_idle();
    wr(`OSS_ADR_CTRL, 32'h0);
    weight <= 24'd0;
    $display("done automatic");
  endtask

  task automatic t_latch();
    repeat (4) @(posedge mclk);
    chk("latch disabled", 1'b0, targetRun);
    wr(`OSS_ADR_CTRL, 32'h4);
    repeat (4) @(posedge mclk);
    chk("latch default off", 1'b0, targetRun);
    press(2);
    chk("fill start", 1'b1, targetRun);
    press(1);
    chk("fill pause", 1'b0, targetRun);
    press(0);
    chk("fill resume", 1'b1, targetRun);
    wr(`OSS_ADR_CMD, 32'h10);
    repeat (3) @(posedge mclk);
    chk("target stop", 1'b0, targetRun);
    wr(`OSS_ADR_CMD, 32'h8);
    repeat (3) @(posedge mclk);
    chk("target start", 1'b1, targetRun);
    $display("done target latch");
  endtask

  // a hung handshake ends the run here; command and idle waits give up after 400 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    final_report();
  end

  initial begin
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    t_regs();
    t_run();
    t_loop();
    t_fail();
    t_auto();
    t_latch();
    final_report();
  end
endmodule
